/* File: design/vt_trace_and_auto_ais_control.sv */
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vt_trace_consts.svh"

module vt_trace_and_auto_ais_control (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire vt_trace_pkg::trace_in_s j2_in,
   input wire vt_trace_pkg::trace_in_s n2_in,
   input wire vt_trace_pkg::defects_s defects,
   input wire logic ais_master_en,
   output logic ais_insert,
   output logic tc_active,
   output logic irq
);

   vt_trace_pkg::state_s s;
   vt_trace_pkg::state_s n;

   // Length code to index of the last byte of a message.
   function automatic logic [5:0] last_idx(input logic [1:0] len);
      if (len[1])
         last_idx = `LAST_64;
      else if (len[0])
         last_idx = `LAST_16;
      else
         last_idx = `LAST_1;
   endfunction

   // Persistence count needed before a message is accepted.
   function automatic logic [2:0] thr_cnt(input logic thr);
      thr_cnt = thr ? `THR_HIGH : `THR_LOW;
   endfunction

   // Source selection and per-byte working values.
   logic tc_on;
   vt_trace_pkg::trace_in_s src;
   logic [7:0] b;
   logic [5:0] idx;
   logic [5:0] last;
   logic start;
   logic take;
   logic done;
   logic abort;
   logic mis_n;
   logic [2:0] cnt_n;
   logic new_msg;
   logic ais_want;
   logic [2:0] ev;

   always_comb
   begin
      n = s;
      tc_on = (s.ctrl.tc_en == `TC_16) || (s.ctrl.tc_en == `TC_1);
      // Tandem mode takes the N2 stream into the same buffers.
      src = tc_on ? n2_in : j2_in;
      b = src.data;
      last = last_idx(s.ctrl.len);
      start = s.ctrl.msg_type && b[`START_BIT];
      take = 1'b0;
      done = 1'b0;
      abort = 1'b0;
      idx = start ? 6'h00 : s.widx;
      mis_n = s.mis;
      cnt_n = s.pcnt;
      new_msg = 1'b0;

      // Boundary hunting and byte assembly.
      if (src.valid)
      begin
         unique case (s.phase)
            vt_trace_pkg::HUNT:
            begin
               if (start)
                  take = 1'b1;
               else if (!s.ctrl.msg_type && b == `LINE_FEED)
               begin
                  n.phase = vt_trace_pkg::FILL;
                  n.widx = 6'h00;
               end
            end
            vt_trace_pkg::FILL:
               take = s.ctrl.msg_type ? 1'b1 : 1'b1;
         endcase
      end

      // A type 1 start byte in mid-message means the last one was short.
      if (take && start && s.phase == vt_trace_pkg::FILL && s.widx != 6'h00)
         cnt_n = 3'h0;

      if (take)
      begin
         mis_n = ((idx == 6'h00) ? 1'b0 : s.mis) | (s.cap[idx] != b);
         n.cap[idx] = b;
         if (!s.ctrl.msg_type)
         begin
            // Line feed closes the message and must land on the last byte.
            if (b == `LINE_FEED)
            begin
               done = (idx == last);
               abort = (idx != last);
               n.widx = 6'h00;
            end
            else if (idx == last)
            begin
               abort = 1'b1;
               n.phase = vt_trace_pkg::HUNT;
            end
            else
               n.widx = idx + 6'h01;
         end
         else if (idx == last)
         begin
            done = 1'b1;
            n.widx = 6'h00;
            n.phase = vt_trace_pkg::HUNT;
         end
         else
         begin
            n.widx = idx + 6'h01;
            n.phase = vt_trace_pkg::FILL;
         end
         n.mis = mis_n;
      end

      // Persistence: identical messages in a row, saturating at the top threshold.
      if (abort)
         cnt_n = 3'h0;
      else if (done)
      begin
         if (mis_n)
            cnt_n = 3'h1;
         else if (cnt_n < `THR_HIGH)
            cnt_n = cnt_n + 3'h1;
         // Only the step onto the threshold loads, so one event per new message.
         if (cnt_n == thr_cnt(s.ctrl.thr) && cnt_n != s.pcnt)
         begin
            n.act = n.cap;
            new_msg = 1'b1;
         end
      end
      n.pcnt = cnt_n;

      // Auto AIS-V toward the egress E1 side, held only while a defect stands.
      ais_want = ais_master_en &&
         ((s.aais1[5] && defects.ais) ||
          (s.aais1[4] && defects.uneq) ||
          (s.aais1[2] && defects.lop) ||
          (s.aais1[1] && defects.plm));
      n.ais_out = ais_want;
      n.tc_active = tc_on;

      ev = 3'h0;
      ev[`INT_NEW] = new_msg;
      ev[`INT_AIS_ON] = ais_want && !s.ais_out;
      ev[`INT_AIS_OFF] = !ais_want && s.ais_out;

      // Register writes; reserved bits are masked away.
      n.int_stat = s.int_stat;
      if (bus_wr)
      begin
         unique case (bus_addr)
            `CTRL_OFS: n.ctrl = bus_wdata & `CTRL_WMASK;
            `AAIS1_OFS: n.aais1 = bus_wdata & `AAIS1_WMASK;
            `INT_STAT_OFS: n.int_stat = s.int_stat & ~bus_wdata[2:0];
            `INT_MASK_OFS: n.int_mask = bus_wdata[2:0];
            `BUF_ADDR_OFS: n.buf_addr = bus_wdata[5:0];
            `BUF_DATA_OFS: n.exp[s.buf_addr] = bus_wdata;
            default: ;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      n.int_stat = n.int_stat | ev;
      n.irq = |(n.int_stat & n.int_mask);

      // Read data stands only in the cycle after the strobe.
      n.rdata = 8'h00;
      if (bus_rd)
      begin
         unique case (bus_addr)
            `CTRL_OFS: n.rdata = s.ctrl & `CTRL_WMASK;
            `AAIS1_OFS: n.rdata = s.aais1 & `AAIS1_WMASK;
            `INT_STAT_OFS: n.rdata = {5'h00, s.int_stat};
            `INT_MASK_OFS: n.rdata = {5'h00, s.int_mask};
            `BUF_ADDR_OFS: n.rdata = {2'h0, s.buf_addr};
            `BUF_DATA_OFS: n.rdata = s.ctrl.buf_sel ? s.exp[s.buf_addr]
                                                     : s.act[s.buf_addr];
            default: n.rdata = 8'h00;
         endcase
      end
   end

   // Every bit starts at zero except the hunt state.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.phase <= vt_trace_pkg::HUNT;
      end
      else
         s <= n;
   end

   assign bus_rdata = s.rdata;
   assign ais_insert = s.ais_out;
   assign tc_active = s.tc_active;
   assign irq = s.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   ais_follows_defect_a: assert property (
      (ais_master_en && s.aais1[5] && defects.ais) |=> ais_insert)
      else $error("AIS-V defect did not insert AIS.");
   uneq_insert_a: assert property (
      (ais_master_en && s.aais1[4] && defects.uneq) |=> ais_insert)
      else $error("UNEQ-V defect did not insert AIS.");
   lop_insert_a: assert property (
      (ais_master_en && s.aais1[2] && defects.lop) |=> ais_insert)
      else $error("LOP-V defect did not insert AIS.");
   plm_insert_a: assert property (
      (ais_master_en && s.aais1[1] && defects.plm) |=> ais_insert)
      else $error("PLM-V defect did not insert AIS.");
   master_gate_a: assert property (
      !ais_master_en |=> !ais_insert)
      else $error("AIS inserted without master enable.");
   ais_ends_a: assert property (
      !(defects.ais || defects.uneq || defects.lop || defects.plm) |=> !ais_insert)
      else $error("AIS held after defects cleared.");
   reserved_zero_a: assert property (
      $past(bus_rd) && $past(bus_addr) == `AAIS1_OFS |-> (bus_rdata & ~`AAIS1_WMASK) == 8'h00)
      else $error("Reserved bits read nonzero.");
   ctrl_rw_a: assert property (
      bus_wr && bus_addr == `CTRL_OFS ##1 bus_rd && bus_addr == `CTRL_OFS && !bus_wr
      |=> bus_rdata == ($past(bus_wdata, 2) & `CTRL_WMASK))
      else $error("Control write not read back.");
   tc_mode_a: assert property (
      s.ctrl.tc_en == 2'h2 |=> !tc_active)
      else $error("Reserved TC code enabled tandem mode.");
   expected_read_a: assert property (
      bus_rd && bus_addr == `BUF_DATA_OFS && s.ctrl.buf_sel |=> bus_rdata == $past(s.exp[s.buf_addr]))
      else $error("Expected buffer not returned.");
   accept_thr_a: assert property (
      new_msg |-> cnt_n == (s.ctrl.thr ? 3'h5 : 3'h3))
      else $error("Message accepted at wrong count.");
   // The level output is registered beside the status, so it matches in the same cycle.
   irq_level_a: assert property (
      |(s.int_stat & s.int_mask) |-> irq)
      else $error("Interrupt not raised.");

   // A quiet status must leave the interrupt line low.
   irq_low_a: assert property (
      !(|(s.int_stat & s.int_mask)) |-> !irq)
      else $error("Interrupt raised with nothing pending.");

   // The bus returns zero outside the answer cycle, so a stale read cannot be mistaken.
   rdata_idle_a: assert property (
      !$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("Read data outside the answer cycle.");

   // The reserved control bit must never read back as one.
   ctrl_reserved_a: assert property (
      $past(bus_rd) && $past(bus_addr) == `CTRL_OFS |-> bus_rdata[5] == 1'b0)
      else $error("Reserved control bit read nonzero.");

   // Both legal tandem codes must raise tc_active in the next cycle.
   tc_enable_a: assert property (
      (s.ctrl.tc_en == `TC_16 || s.ctrl.tc_en == `TC_1) |=> tc_active)
      else $error("Tandem code did not enable tandem mode.");

   // Software data lands in the expected buffer at the written index.
   exp_write_a: assert property (
      bus_wr && bus_addr == `BUF_DATA_OFS |=> s.exp[$past(s.buf_addr)] == $past(bus_wdata))
      else $error("Expected buffer write lost.");

   // A wrong-length message must restart persistence from nothing.
   abort_reset_a: assert property (
      abort |=> s.pcnt == 3'h0)
      else $error("Persistence kept after a wrong-length message.");

   // In start-bit framing a byte without the top bit cannot leave the hunt.
   hunt_drop_a: assert property (
      src.valid && s.phase == vt_trace_pkg::HUNT && s.ctrl.msg_type && !start
      |=> s.phase == vt_trace_pkg::HUNT)
      else $error("Hunt left without a boundary.");

   // Each accepted message must leave its event behind, even against a clear.
   new_msg_evt_a: assert property (
      new_msg |=> s.int_stat[`INT_NEW])
      else $error("Accepted message not flagged.");

   // Start of insertion is flagged in the same edge that raises the output.
   ais_on_evt_a: assert property (
      $rose(ais_insert) |-> s.int_stat[`INT_AIS_ON])
      else $error("Insertion start not flagged.");

   // End of insertion is flagged in the same edge that drops the output.
   ais_off_evt_a: assert property (
      $fell(ais_insert) |-> s.int_stat[`INT_AIS_OFF])
      else $error("Insertion end not flagged.");

endmodule
`default_nettype wire

/* File: design/vt_trace_consts.svh */
`ifndef VT_TRACE_CONSTS_SVH
`define VT_TRACE_CONSTS_SVH
// Register offsets on the 8-bit register port.
`define CTRL_OFS 8'h71
`define AAIS1_OFS 8'h72
`define INT_STAT_OFS 8'h74
`define INT_MASK_OFS 8'h75
`define BUF_ADDR_OFS 8'h76
`define BUF_DATA_OFS 8'h77
// Writable bits; everything else is reserved and reads zero.
`define CTRL_WMASK 8'hdf
`define AAIS1_WMASK 8'h36
`define INT_WMASK 8'h07
// Tandem connection codes.
`define TC_16 2'h1
`define TC_1 2'h3
// Last byte index for each length code.
`define LAST_1 6'h00
`define LAST_16 6'h0f
`define LAST_64 6'h3f
// Persistence thresholds.
`define THR_LOW 3'h3
`define THR_HIGH 3'h5
`define LINE_FEED 8'h0a
`define START_BIT 7
// Interrupt status bits.
`define INT_NEW 0
`define INT_AIS_ON 1
`define INT_AIS_OFF 2
`endif

/* File: design/vt_trace_pkg.sv */
package vt_trace_pkg;
   typedef struct packed {
      logic [1:0] tc_en;
      logic rsvd;
      logic buf_sel;
      logic thr;
      logic msg_type;
      logic [1:0] len;
   } ctrl_s;
   typedef struct packed {
      logic ais;
      logic uneq;
      logic lop;
      logic plm;
   } defects_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } trace_in_s;
   typedef enum logic [1:0] {HUNT = 2'b01, FILL = 2'b10} phase_e;
   typedef logic [63:0][7:0] msg_t;
   typedef struct packed {
      ctrl_s ctrl;
      logic [7:0] aais1;
      logic [2:0] int_stat;
      logic [2:0] int_mask;
      logic [5:0] buf_addr;
      logic [7:0] rdata;
      logic irq;
      logic ais_out;
      logic tc_active;
      phase_e phase;
      logic [5:0] widx;
      logic mis;
      logic [2:0] pcnt;
      msg_t cap;
      msg_t act;
      msg_t exp;
   } state_s;
endpackage

/* File: verification/vt_stream_src.sv */
`timescale 1ns/1ns
`default_nettype none
// Incoming VT path model: sends trace messages on the J2 or the N2 stream.
module vt_stream_src (
   input wire logic clk,
   output var vt_trace_pkg::trace_in_s j2,
   output var vt_trace_pkg::trace_in_s n2
);
   // Both streams start idle.
   initial
   begin
      j2 = '0;
      n2 = '0;
   end
   // Sends n line-feed bytes on J2, each followed by an idle cycle.
   task automatic send_lf(input int n);
      repeat (n)
      begin
         @(posedge clk);
         j2 <= {1'b1, 8'h0a};
         @(posedge clk);
         j2 <= {1'b0, 8'hf5};
      end
   endtask
   // Sends one message reps times; only byte 0 has its top bit set.
   // Idle data shows the inverse of the last byte, so a stale byte never looks fresh.
   task automatic sendn(input logic tc, input logic [7:0] seed, input int len, input int reps);
      vt_trace_pkg::trace_in_s b;
      repeat (reps)
      begin
         for (int i = 0; i < len; i++)
         begin
            b = {1'b1, i == 0, seed[6:0]};
            @(posedge clk);
            if (tc)
               n2 <= b;
            else
               j2 <= b;
         end
         @(posedge clk);
         j2 <= {1'b0, ~j2.data};
         n2 <= {1'b0, ~n2.data};
      end
   endtask
endmodule
`default_nettype wire

/* File: verification/vt_trace_and_auto_ais_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vt_trace_consts.svh"
module vt_trace_and_auto_ais_control_tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic ais_master_en = 1'b0;
   logic ais_insert;
   logic tc_active;
   logic irq;
   vt_trace_pkg::trace_in_s j2_in;
   vt_trace_pkg::trace_in_s n2_in;
   vt_trace_pkg::defects_s defects = '0;
   int n_fail = 0;
   int tests_run = 0;
   logic [7:0] en_bit [4] = '{8'h20, 8'h10, 8'h04, 8'h02};

   // The 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   vt_stream_src src (.clk(sys_clk), .j2(j2_in), .n2(n2_in));
   vt_trace_and_auto_ais_control dut (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .j2_in(j2_in), .n2_in(n2_in), .defects(defects), .ais_master_en(ais_master_en),
      .ais_insert(ais_insert), .tc_active(tc_active), .irq(irq));

   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   // Read data is only valid in the cycle after the strobe, so it is taken there.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      chk("bus_rdata", bus_rdata, exp);
   endtask
   // Reads one byte of the trace buffer selected by the control register.
   task automatic bchk(input logic [7:0] idx, input logic [7:0] exp);
      wr(`BUF_ADDR_OFS, idx);
      rchk(`BUF_DATA_OFS, exp);
   endtask
   // Registered outputs get two edges to settle before they are looked at.
   task automatic wait2;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic ais_step(input logic [3:0] d, input logic m, input logic e);
      @(posedge sys_clk);
      defects <= d;
      ais_master_en <= m;
      wait2;
      chk("ais_insert", 8'(ais_insert), 8'(e));
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // A hang counts as a mismatch and still ends with the report.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      tally_and_finish;
   end

   // Main sequence.
   initial
   begin
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rchk(`CTRL_OFS, 8'h00);
      rchk(`AAIS1_OFS, 8'h00);
      wr(`CTRL_OFS, 8'hff);
      rchk(`CTRL_OFS, 8'hdf);
      wr(`AAIS1_OFS, 8'hff);
      rchk(`AAIS1_OFS, 8'h36);
      wr(8'h00, 8'hff);
      rchk(8'h00, 8'h00);
      $display("Test registers done");
      // Threshold 0, start-bit framing, one-byte length: the third copy loads.
      wr(`CTRL_OFS, 8'h04);
      wr(`INT_MASK_OFS, 8'h01);
      src.sendn(1'b0, 8'h05, 1, 2);
      bchk(8'h00, 8'h00);
      chk("irq", 8'(irq), 8'h00);
      src.sendn(1'b0, 8'h05, 1, 1);
      bchk(8'h00, 8'h85);
      chk("irq", 8'(irq), 8'h01);
      wr(`INT_STAT_OFS, 8'h01);
      wait2;
      chk("irq", 8'(irq), 8'h00);
      // Threshold 1 with sixteen-byte messages: four copies are not enough.
      wr(`CTRL_OFS, 8'h0d);
      src.sendn(1'b0, 8'h21, 16, 4);
      bchk(8'h0f, 8'h00);
      src.sendn(1'b0, 8'h21, 16, 1);
      bchk(8'h0f, 8'h21);
      bchk(8'h00, 8'ha1);
      $display("Test trace acceptance done");
      // The expected buffer is software data; the select bit steers reads.
      wr(`CTRL_OFS, 8'h1d);
      wr(`BUF_ADDR_OFS, 8'h03);
      wr(`BUF_DATA_OFS, 8'h5a);
      bchk(8'h03, 8'h5a);
      wr(`CTRL_OFS, 8'h0d);
      bchk(8'h03, 8'h21);
      $display("Test buffer select done");
      for (int c = 0; c < 4; c++)
      begin
         wr(`CTRL_OFS, {c[1:0], 6'h0d});
         wait2;
         chk("tc_active", 8'(tc_active), 8'((c == 1) || (c == 3)));
      end
      // Sixteen-byte tandem mode takes N2 into the shared buffer and ignores J2.
      wr(`CTRL_OFS, 8'h4d);
      src.sendn(1'b1, 8'h33, 16, 5);
      bchk(8'h0f, 8'h33);
      src.sendn(1'b0, 8'h44, 16, 5);
      bchk(8'h0f, 8'h33);
      $display("Test tandem connection done");
      // Line feed framing, one-byte length: the first line feed only finds the boundary.
      wr(`CTRL_OFS, 8'h00);
      src.send_lf(3);
      bchk(8'h00, 8'hb3);
      src.send_lf(1);
      bchk(8'h00, 8'h0a);
      $display("Test line feed framing done");
      // Each enable bit reacts to its own defect only, and only with the master set.
      for (int k = 0; k < 4; k++)
      begin
         wr(`AAIS1_OFS, en_bit[k]);
         ais_step(4'hf ^ (4'h8 >> k), 1'b1, 1'b0);
         ais_step(4'h8 >> k, 1'b1, 1'b1);
         ais_step(4'h8 >> k, 1'b0, 1'b0);
         ais_step(4'h0, 1'b1, 1'b0);
      end
      rchk(`INT_STAT_OFS, 8'h07);
      wr(`INT_STAT_OFS, 8'h07);
      rchk(`INT_STAT_OFS, 8'h00);
      $display("Test auto AIS done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
